// File: logic/noload_cfg.svh
// constants of the per-phase no-load detector
`ifndef NOLOAD_CFG_SVH
`define NOLOAD_CFG_SVH

// register index width on the serial-port side
`define NL_ADDR_W 4
// register indices
`define NL_ADDR_ACTIVE_THR 4'h0
`define NL_ADDR_REACTIVE_THR 4'h1
`define NL_ADDR_APPARENT_THR 4'h2
`define NL_ADDR_STATUS 4'h3
`define NL_ADDR_MASK 4'h4
`define NL_ADDR_PHASE_STATE 4'h5
`define NL_ADDR_FULL_SCALE 4'h6

// flag positions in the second status and mask registers
`define NL_FLAG_TOTAL 0
`define NL_FLAG_FUND 1
`define NL_FLAG_APPARENT 2

// lowest bit of each three-bit field in the phase state register
`define NL_PH_TOTAL_LSB 0
`define NL_PH_FUND_LSB 3
`define NL_PH_APPARENT_LSB 6

// reset values
`define NL_THR_RESET 24'h000000
`define NL_MASK_RESET 3'h0

// power produced with full-scale converter inputs
`define NL_FULL_SCALE_POWER 28'h1FF6A6B

`endif

// File: logic/noload_pkg.sv
// types shared by the no-load detector files
package noload_pkg;

   // signed power word as the signal processor carries it
   typedef logic signed [27:0] dsp_word_t;
   // signed threshold as software programs it
   typedef logic signed [23:0] threshold_t;
   // register selected by the current access
   typedef enum {
      SEL_ACTIVE_THR,
      SEL_REACTIVE_THR,
      SEL_APPARENT_THR,
      SEL_STATUS,
      SEL_MASK,
      SEL_PHASE_STATE,
      SEL_FULL_SCALE,
      SEL_NONE
   } reg_sel_e;

endpackage : noload_pkg

// File: logic/noload_phase_cmp.sv
// one magnitude-versus-threshold comparison for one phase
`timescale 1ns/1ps

module noload_phase_cmp (
   input wire logic signed [27:0] power,
   input wire logic signed [23:0] threshold,
   output logic at_or_below
);

   logic [27:0] magnitude;
   logic [27:0] limit;

   // unsigned magnitude; the most negative code maps to 2^27 correctly
   assign magnitude = power[27] ? 28'(-power) : 28'(power);
   assign limit = {4'h0, threshold};

   // a negative threshold takes this term out of the decision
   assign at_or_below = threshold[23] ? 1'b1 : (magnitude <= limit);

endmodule : noload_phase_cmp

// File: logic/noload_flag_unit.sv
// phase state bits and sticky flag of one no-load detector
`timescale 1ns/1ps

module noload_flag_unit (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic update,
   input wire logic enable,
   input wire logic [2:0] cond,
   input wire logic clear,
   output logic [2:0] phase_bits,
   output logic flag
);

   logic [2:0] phase_next;
   logic changed;

   // a disabled detector reports every phase out of no-load
   assign phase_next = enable ? cond : 3'h0;
   assign changed = update && (phase_next != phase_bits);

   // phase bits move only when a phase enters or leaves no-load
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_bits <= 3'h0;
      end else if (changed) begin
         phase_bits <= phase_next;
      end
   end

   // sticky flag; a new change wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag <= 1'b0;
      end else if (changed) begin
         flag <= 1'b1;
      end else if (clear) begin
         flag <= 1'b0;
      end
   end

endmodule : noload_flag_unit

// File: logic/phase_no_load_detector.sv
// per-phase no-load detection with status, mask and interrupt line
`timescale 1ns/1ps
`include "noload_cfg.svh"

// How it works
// - phase enters total no-load when both total powers are within thresholds
// - total no-load phase stops total energy accumulation and its pulses
// - thresholds share the scale of the full-scale power constant
// - both active and reactive thresholds negative disable total detection
// - thresholds read as 32 bits, top four zero, sign extended to 28
// - total flag, status bit 0, sets when any phase triggers
// - phase bits 2:0 update together with the total flag
// - mask bit 0 drives interrupt line low on total entry or exit
// - host reads phase state, then writes one to clear flag and line
// - fundamental no-load uses fundamental powers against shared thresholds
// - fundamental no-load phase stops fundamental energy and its pulses
// - negative shared thresholds also disable fundamental detection
// - fundamental flag, status bit 1, with phase bits 5:3
// - mask bit 1 enables interrupt; write one clears flag and line
// - apparent no-load when apparent magnitude at or below its threshold
// - apparent threshold uses the same full-scale power constant
// - negative apparent threshold disables apparent detection
// - apparent flag, status bit 2, sets when any phase triggers
// - phase bits 8:6 update together with the apparent flag
// - mask bit 2 drives interrupt line low on apparent entry or exit
module phase_no_load_detector (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic POWER_UPDATE,
   input wire logic signed [27:0] TOTAL_ACTIVE_A,
   input wire logic signed [27:0] TOTAL_ACTIVE_B,
   input wire logic signed [27:0] TOTAL_ACTIVE_C,
   input wire logic signed [27:0] TOTAL_REACTIVE_A,
   input wire logic signed [27:0] TOTAL_REACTIVE_B,
   input wire logic signed [27:0] TOTAL_REACTIVE_C,
   input wire logic signed [27:0] FUND_ACTIVE_A,
   input wire logic signed [27:0] FUND_ACTIVE_B,
   input wire logic signed [27:0] FUND_ACTIVE_C,
   input wire logic signed [27:0] FUND_REACTIVE_A,
   input wire logic signed [27:0] FUND_REACTIVE_B,
   input wire logic signed [27:0] FUND_REACTIVE_C,
   input wire logic signed [27:0] APPARENT_A,
   input wire logic signed [27:0] APPARENT_B,
   input wire logic signed [27:0] APPARENT_C,
   input wire logic REG_REQ,
   input wire logic REG_WRITE,
   input wire logic [3:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   output logic REG_READY,
   output logic [2:0] TOTAL_ACC_ENABLE,
   output logic [2:0] FUND_ACC_ENABLE,
   output logic [2:0] APPARENT_ACC_ENABLE,
   output logic SECOND_INTERRUPT_LINE_B
);

   // reset synchroniser
   logic rst_meta_reg;
   logic rst_n;

   // software-visible thresholds and interrupt mask
   noload_pkg::threshold_t active_power_noload_threshold_reg;
   noload_pkg::threshold_t reactive_power_noload_threshold_reg;
   noload_pkg::threshold_t apparent_power_noload_threshold_reg;
   logic [2:0] second_interrupt_mask_reg;

   // register access decode
   noload_pkg::reg_sel_e reg_sel;
   logic wr_strobe;
   logic rd_strobe;
   logic [31:0] rdata_next;
   logic [31:0] rdata_reg;
   logic ready_reg;

   // per-phase power vectors, index 0 is phase A
   noload_pkg::dsp_word_t tot_act [3];
   noload_pkg::dsp_word_t tot_rea [3];
   noload_pkg::dsp_word_t fun_act [3];
   noload_pkg::dsp_word_t fun_rea [3];
   noload_pkg::dsp_word_t app_pwr [3];

   // comparison results per phase
   logic [2:0] tot_act_low;
   logic [2:0] tot_rea_low;
   logic [2:0] fun_act_low;
   logic [2:0] fun_rea_low;
   logic [2:0] app_low;
   logic [2:0] total_cond;
   logic [2:0] fund_cond;

   // detector enables
   logic reactive_circuit_on;
   logic apparent_circuit_on;

   // detector state
   logic [2:0] total_noload_phase_bits;
   logic [2:0] fundamental_noload_phase_bits;
   logic [2:0] apparent_noload_phase_bits;
   logic total_noload_flag;
   logic fundamental_noload_flag;
   logic apparent_noload_flag;
   logic [2:0] status_flags;
   logic [2:0] status_clear;
   logic [8:0] noload_phase_state;

   // interrupt line
   logic irq_b_reg;

   // reset release through two flip-flops
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // gather the phase powers into indexable vectors
   assign tot_act[0] = TOTAL_ACTIVE_A;
   assign tot_act[1] = TOTAL_ACTIVE_B;
   assign tot_act[2] = TOTAL_ACTIVE_C;
   assign tot_rea[0] = TOTAL_REACTIVE_A;
   assign tot_rea[1] = TOTAL_REACTIVE_B;
   assign tot_rea[2] = TOTAL_REACTIVE_C;
   assign fun_act[0] = FUND_ACTIVE_A;
   assign fun_act[1] = FUND_ACTIVE_B;
   assign fun_act[2] = FUND_ACTIVE_C;
   assign fun_rea[0] = FUND_REACTIVE_A;
   assign fun_rea[1] = FUND_REACTIVE_B;
   assign fun_rea[2] = FUND_REACTIVE_C;
   assign app_pwr[0] = APPARENT_A;
   assign app_pwr[1] = APPARENT_B;
   assign app_pwr[2] = APPARENT_C;

   // five comparisons for each phase
   for (genvar ph = 0; ph < 3; ph++) begin : g_phase
      noload_phase_cmp u_tot_act (
         .power(tot_act[ph]),
         .threshold(active_power_noload_threshold_reg),
         .at_or_below(tot_act_low[ph])
      );
      noload_phase_cmp u_tot_rea (
         .power(tot_rea[ph]),
         .threshold(reactive_power_noload_threshold_reg),
         .at_or_below(tot_rea_low[ph])
      );
      noload_phase_cmp u_fun_act (
         .power(fun_act[ph]),
         .threshold(active_power_noload_threshold_reg),
         .at_or_below(fun_act_low[ph])
      );
      noload_phase_cmp u_fun_rea (
         .power(fun_rea[ph]),
         .threshold(reactive_power_noload_threshold_reg),
         .at_or_below(fun_rea_low[ph])
      );
      noload_phase_cmp u_app (
         .power(app_pwr[ph]),
         .threshold(apparent_power_noload_threshold_reg),
         .at_or_below(app_low[ph])
      );
   end

   assign total_cond = tot_act_low & tot_rea_low;
   assign fund_cond = fun_act_low & fun_rea_low;

   // both shared thresholds negative turn the circuit off
   // same switch governs the fundamental circuit
   // a lone negative reactive threshold only drops that term
   assign reactive_circuit_on = !(active_power_noload_threshold_reg[23]
      && reactive_power_noload_threshold_reg[23]);
   // negative apparent threshold turns its circuit off
   assign apparent_circuit_on = !apparent_power_noload_threshold_reg[23];

   // host write of one clears the matching flag
   // same clear path for the fundamental flag
   assign status_clear = (wr_strobe && reg_sel == noload_pkg::SEL_STATUS)
      ? REG_WDATA[2:0] : 3'h0;

   // phase bits move with the flag
   noload_flag_unit u_total (
      .clk(CORE_CLK),
      .rst_n(rst_n),
      .update(POWER_UPDATE),
      .enable(reactive_circuit_on),
      .cond(total_cond),
      .clear(status_clear[`NL_FLAG_TOTAL]),
      .phase_bits(total_noload_phase_bits),
      .flag(total_noload_flag)
   );

   noload_flag_unit u_fund (
      .clk(CORE_CLK),
      .rst_n(rst_n),
      .update(POWER_UPDATE),
      .enable(reactive_circuit_on),
      .cond(fund_cond),
      .clear(status_clear[`NL_FLAG_FUND]),
      .phase_bits(fundamental_noload_phase_bits),
      .flag(fundamental_noload_flag)
   );

   // phase bits move with the flag
   noload_flag_unit u_app (
      .clk(CORE_CLK),
      .rst_n(rst_n),
      .update(POWER_UPDATE),
      .enable(apparent_circuit_on),
      .cond(app_low),
      .clear(status_clear[`NL_FLAG_APPARENT]),
      .phase_bits(apparent_noload_phase_bits),
      .flag(apparent_noload_flag)
   );

   // status and phase state images
   assign status_flags = {apparent_noload_flag, fundamental_noload_flag,
      total_noload_flag};
   assign noload_phase_state = {apparent_noload_phase_bits,
      fundamental_noload_phase_bits, total_noload_phase_bits};

   // suppress total energy and pulses per phase
   assign TOTAL_ACC_ENABLE = ~total_noload_phase_bits;
   // suppress fundamental energy and pulses per phase
   assign FUND_ACC_ENABLE = ~fundamental_noload_phase_bits;
   // suppress apparent energy and pulses per phase
   assign APPARENT_ACC_ENABLE = ~apparent_noload_phase_bits;

   // access strobes; the ready cycle of a held request takes nothing
   assign wr_strobe = REG_REQ && REG_WRITE && !ready_reg;
   assign rd_strobe = REG_REQ && !REG_WRITE && !ready_reg;

   // address decode
   always_comb begin
      if (REG_ADDR == `NL_ADDR_ACTIVE_THR) begin
         reg_sel = noload_pkg::SEL_ACTIVE_THR;
      end else if (REG_ADDR == `NL_ADDR_REACTIVE_THR) begin
         reg_sel = noload_pkg::SEL_REACTIVE_THR;
      end else if (REG_ADDR == `NL_ADDR_APPARENT_THR) begin
         reg_sel = noload_pkg::SEL_APPARENT_THR;
      end else if (REG_ADDR == `NL_ADDR_STATUS) begin
         reg_sel = noload_pkg::SEL_STATUS;
      end else if (REG_ADDR == `NL_ADDR_MASK) begin
         reg_sel = noload_pkg::SEL_MASK;
      end else if (REG_ADDR == `NL_ADDR_PHASE_STATE) begin
         reg_sel = noload_pkg::SEL_PHASE_STATE;
      end else if (REG_ADDR == `NL_ADDR_FULL_SCALE) begin
         reg_sel = noload_pkg::SEL_FULL_SCALE;
      end else begin
         reg_sel = noload_pkg::SEL_NONE;
      end
   end

   // threshold writes keep the low 24 bits of the word
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         active_power_noload_threshold_reg <= `NL_THR_RESET;
         reactive_power_noload_threshold_reg <= `NL_THR_RESET;
         apparent_power_noload_threshold_reg <= `NL_THR_RESET;
      end else if (wr_strobe) begin
         if (reg_sel == noload_pkg::SEL_ACTIVE_THR) begin
            active_power_noload_threshold_reg <= REG_WDATA[23:0];
         end else if (reg_sel == noload_pkg::SEL_REACTIVE_THR) begin
            reactive_power_noload_threshold_reg <= REG_WDATA[23:0];
         end else if (reg_sel == noload_pkg::SEL_APPARENT_THR) begin
            apparent_power_noload_threshold_reg <= REG_WDATA[23:0];
         end
      end
   end

   // mask register, all sources disabled after reset
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         second_interrupt_mask_reg <= `NL_MASK_RESET;
      end else if (wr_strobe && reg_sel == noload_pkg::SEL_MASK) begin
         second_interrupt_mask_reg <= REG_WDATA[2:0];
      end
   end

   // read data selection
   always_comb begin
      rdata_next = 32'h0000_0000;
      case (reg_sel)
         // 24-bit value sign extended to 28, top nibble zero
         noload_pkg::SEL_ACTIVE_THR: begin
            rdata_next = {4'h0, {4{active_power_noload_threshold_reg[23]}},
               active_power_noload_threshold_reg};
         end
         noload_pkg::SEL_REACTIVE_THR: begin
            rdata_next = {4'h0,
               {4{reactive_power_noload_threshold_reg[23]}},
               reactive_power_noload_threshold_reg};
         end
         noload_pkg::SEL_APPARENT_THR: begin
            rdata_next = {4'h0,
               {4{apparent_power_noload_threshold_reg[23]}},
               apparent_power_noload_threshold_reg};
         end
         noload_pkg::SEL_STATUS: begin
            rdata_next = {29'h0000_0000, status_flags};
         end
         noload_pkg::SEL_MASK: begin
            rdata_next = {29'h0000_0000, second_interrupt_mask_reg};
         end
         noload_pkg::SEL_PHASE_STATE: begin
            rdata_next = {23'h00_0000, noload_phase_state};
         end
         // thresholds and powers share this full-scale figure
         // apparent scale uses the same constant
         noload_pkg::SEL_FULL_SCALE: begin
            rdata_next = {4'h0, `NL_FULL_SCALE_POWER};
         end
         default: begin
            rdata_next = 32'h0000_0000;
         end
      endcase
   end

   // read data held until the next read
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 32'h0000_0000;
      end else if (rd_strobe) begin
         rdata_reg <= rdata_next;
      end
   end

   // one-cycle ready per request; the host holds the request until then
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ready_reg <= 1'b0;
      end else begin
         ready_reg <= REG_REQ && !ready_reg;
      end
   end

   assign REG_RDATA = rdata_reg;
   assign REG_READY = ready_reg;

   // total flag pulls the line when mask bit 0 is set
   // fundamental flag pulls it under mask bit 1
   // apparent flag pulls it under mask bit 2
   // line stays low while any enabled flag stands
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         irq_b_reg <= 1'b1;
      end else begin
         irq_b_reg <= !(|(status_flags & second_interrupt_mask_reg));
      end
   end

   assign SECOND_INTERRUPT_LINE_B = irq_b_reg;

endmodule : phase_no_load_detector

// File: tb/noload_monitor.sv
// port checks of the no-load detector
`timescale 1ns/1ps
module noload_monitor (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic POWER_UPDATE,
   input wire logic signed [27:0] TOTAL_ACTIVE_A,
   input wire logic signed [27:0] TOTAL_REACTIVE_A,
   input wire logic signed [27:0] APPARENT_B,
   input wire logic REG_REQ,
   input wire logic REG_WRITE,
   input wire logic [3:0] REG_ADDR,
   input wire logic [31:0] REG_RDATA,
   input wire logic REG_READY,
   input wire logic [2:0] TOTAL_ACC_ENABLE,
   input wire logic [2:0] FUND_ACC_ENABLE,
   input wire logic [2:0] APPARENT_ACC_ENABLE,
   input wire logic SECOND_INTERRUPT_LINE_B
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);
   // magnitude above any positive 24-bit threshold
   function automatic logic big(logic signed [27:0] x);
      return x > 28'sh07FFFFF || x < -28'sh07FFFFF;
   endfunction : big
   // read request, and a write two cycles back
   sequence s_rd;
      REG_REQ && !REG_WRITE;
   endsequence
   sequence s_wr2;
      $past(REG_REQ, 2) && $past(REG_WRITE, 2);
   endsequence
   a_ready_follow: assert property (
      REG_REQ && !REG_READY |=> REG_READY) else $error("ready missing");
   a_ready_single: assert property (
      REG_READY |=> !REG_READY) else $error("ready held too long");
   a_ready_cause: assert property (
      REG_READY |-> $past(REG_REQ)) else $error("ready unasked");
   a_full_scale: assert property (
      s_rd ##0 REG_ADDR == 4'h6 |=> REG_RDATA == 32'h01FF6A6B)
      else $error("full scale word wrong");
   a_thr_format: assert property (
      s_rd ##0 REG_ADDR < 4'h3 |=> REG_RDATA[31:28] == 4'h0
      && REG_RDATA[27:24] == {4{REG_RDATA[23]}})
      else $error("threshold word badly extended");
   a_acc_stable: assert property (
      !$past(POWER_UPDATE) |-> $stable({TOTAL_ACC_ENABLE,
      FUND_ACC_ENABLE, APPARENT_ACC_ENABLE}))
      else $error("enable moved without update");
   a_total_out: assert property (
      POWER_UPDATE && big(TOTAL_ACTIVE_A) && big(TOTAL_REACTIVE_A)
      |=> TOTAL_ACC_ENABLE[0]) else $error("total blocked");
   a_apparent_out: assert property (
      POWER_UPDATE && big(APPARENT_B) |=> APPARENT_ACC_ENABLE[1])
      else $error("apparent blocked");
   a_line_fall: assert property (
      $fell(SECOND_INTERRUPT_LINE_B) |-> $past(POWER_UPDATE, 2)
      || ($past(REG_REQ, 2) && $past(REG_WRITE, 2)))
      else $error("line fell without cause");
   a_line_rise: assert property (
      $rose(SECOND_INTERRUPT_LINE_B) |-> s_wr2)
      else $error("line rose without write");
endmodule : noload_monitor

bind phase_no_load_detector noload_monitor u_mon (
   .CORE_CLK, .RST_B, .POWER_UPDATE, .TOTAL_ACTIVE_A,
   .TOTAL_REACTIVE_A, .APPARENT_B, .REG_REQ, .REG_WRITE, .REG_ADDR,
   .REG_RDATA, .REG_READY, .TOTAL_ACC_ENABLE, .FUND_ACC_ENABLE,
   .APPARENT_ACC_ENABLE, .SECOND_INTERRUPT_LINE_B
);

// File: tb/noload_host.sv
// host controller model on the register port
`timescale 1ns/1ps
module noload_host (
   input wire logic clk,
   input wire logic ready,
   input wire logic [31:0] rdata,
   output logic req,
   output logic wr,
   output logic [3:0] addr,
   output logic [31:0] wdata
);
   // idle bus at time zero
   initial begin
      req = 1'b0;
      wr = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
   end
   // one access: request held until ready is seen high at an edge, for at most eight edges
   task automatic access(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic ok);
      int n;
      @(posedge clk);
      req <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ready !== 1'b1 && n < 8);
      q = rdata;
      ok = ready;
      req <= 1'b0;
      // released lines show the inverse
      wr <= ~w;
      addr <= ~a;
      wdata <= ~d;
   endtask : access
   task automatic service(output logic [31:0] st,
      output logic [31:0] ph, output logic ok);
      logic [31:0] dummy;
      logic k1;
      logic k2;
      access(1'b0, 4'h3, 32'h0, st, k1);
      access(1'b0, 4'h5, 32'h0, ph, k2);
      access(1'b1, 4'h3, st, dummy, ok);
      ok = ok & k1 & k2;
   endtask : service
endmodule : noload_host

// File: tb/tb_phase_no_load_detector.sv
// self-checking bench of the no-load detector
`timescale 1ns/1ps
module tb_phase_no_load_detector;
   logic CORE_CLK, RST_B, POWER_UPDATE, req, wr, rdy, ln, ok;
   logic signed [27:0] pw [15];
   logic [3:0] addr;
   logic [31:0] wd, rd, q, q2;
   logic [2:0] tacc, facc, aacc, mask_m, flags_m;
   logic [8:0] bits_m;
   int mismatches, cmp_count, athr, rthr, vthr;
   // xorshift state, starts at 85953
   logic [31:0] seed = 32'h00014FC1;

   initial begin
      CORE_CLK = 1'b0;
      forever #2 CORE_CLK = ~CORE_CLK;
   end

   phase_no_load_detector DUT (
      .CORE_CLK(CORE_CLK), .RST_B(RST_B), .POWER_UPDATE(POWER_UPDATE),
      .TOTAL_ACTIVE_A(pw[0]), .TOTAL_ACTIVE_B(pw[1]),
      .TOTAL_ACTIVE_C(pw[2]), .TOTAL_REACTIVE_A(pw[3]),
      .TOTAL_REACTIVE_B(pw[4]), .TOTAL_REACTIVE_C(pw[5]),
      .FUND_ACTIVE_A(pw[6]), .FUND_ACTIVE_B(pw[7]),
      .FUND_ACTIVE_C(pw[8]), .FUND_REACTIVE_A(pw[9]),
      .FUND_REACTIVE_B(pw[10]), .FUND_REACTIVE_C(pw[11]),
      .APPARENT_A(pw[12]), .APPARENT_B(pw[13]), .APPARENT_C(pw[14]),
      .REG_REQ(req), .REG_WRITE(wr), .REG_ADDR(addr), .REG_WDATA(wd),
      .REG_RDATA(rd), .REG_READY(rdy), .TOTAL_ACC_ENABLE(tacc),
      .FUND_ACC_ENABLE(facc), .APPARENT_ACC_ENABLE(aacc),
      .SECOND_INTERRUPT_LINE_B(ln)
   );
   noload_host host (.clk(CORE_CLK), .ready(rdy), .rdata(rd),
      .req(req), .wr(wr), .addr(addr), .wdata(wd));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // one threshold term; negative threshold makes it true
   function automatic logic term(int t, logic signed [27:0] x);
      longint m;
      m = (x < 0) ? -longint'(x) : longint'(x);
      return t < 0 || m <= t;
   endfunction : term
   function automatic logic [31:0] exp_rd(int a);
      case (a)
         0: return athr & 32'h0FFFFFFF;
         1: return rthr & 32'h0FFFFFFF;
         2: return vthr & 32'h0FFFFFFF;
         3: return {29'h0, flags_m};
         4: return {29'h0, mask_m};
         5: return {23'h0, bits_m};
         6: return 32'h01FF6A6B;
         default: return 32'h0;
      endcase
   endfunction : exp_rd
   task automatic model_wr(int a, logic [31:0] d);
      case (a)
         0: athr = int'(signed'(d[23:0]));
         1: rthr = int'(signed'(d[23:0]));
         2: vthr = int'(signed'(d[23:0]));
         3: flags_m &= ~d[2:0];
         4: mask_m = d[2:0];
         default: ;
      endcase
   endtask : model_wr
   task automatic model_upd();
      logic [8:0] nb;
      logic en;
      en = !(athr < 0 && rthr < 0);
      for (int i = 0; i < 3; i++) begin
         nb[i] = en && term(athr, pw[i]) && term(rthr, pw[i+3]);
         nb[i+3] = en && term(athr, pw[i+6]) && term(rthr, pw[i+9]);
         nb[i+6] = vthr >= 0 && term(vthr, pw[i+12]);
      end
      for (int d = 0; d < 3; d++) begin
         if (nb[3*d+:3] != bits_m[3*d+:3]) flags_m[d] = 1'b1;
      end
      bits_m = nb;
   endtask : model_upd
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic reg_rw(logic w, int a, logic [31:0] d);
      host.access(w, 4'(a), d, q, ok);
      chk({31'h0, ok}, 32'h1);
      if (!w) chk(q, exp_rd(a));
      else model_wr(a, d);
   endtask : reg_rw
   task automatic chk_line();
      @(posedge CORE_CLK);
      chk({31'h0, ln}, {31'h0, (flags_m & mask_m) == 3'h0});
   endtask : chk_line
   task automatic upd();
      logic [31:0] v;
      @(posedge CORE_CLK);
      for (int i = 0; i < 15; i++) begin
         v = rnd();
         pw[i] <= (v[31:30] != 2'h0) ? 28'(signed'(v[21:0])) : v[27:0];
      end
      POWER_UPDATE <= 1'b1;
      @(posedge CORE_CLK);
      POWER_UPDATE <= 1'b0;
      model_upd();
      @(posedge CORE_CLK);
      chk({23'h0, aacc, facc, tacc}, {23'h0, ~bits_m});
      chk_line();
   endtask : upd
   task automatic serve();
      host.service(q, q2, ok);
      chk({31'h0, ok}, 32'h1);
      chk(q, {29'h0, flags_m});
      chk(q2, {23'h0, bits_m});
      model_wr(3, {29'h0, flags_m});
      chk_line();
   endtask : serve
   task automatic results();
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   // watchdog: the run needs about nine hundred cycles
   initial begin
      repeat (20000) @(posedge CORE_CLK);
      mismatches++;
      results();
   end

   initial begin
      RST_B = 1'b0;
      POWER_UPDATE = 1'b0;
      for (int i = 0; i < 15; i++) pw[i] = 28'h0;
      {athr, rthr, vthr, mask_m, flags_m, bits_m} = '0;
      repeat (8) @(posedge CORE_CLK);
      RST_B <= 1'b1;
      repeat (3) @(posedge CORE_CLK);
      // reset values, then random writes incl. refused places
      for (int a = 0; a < 16; a++) reg_rw(1'b0, a, 32'h0);
      for (int a = 0; a < 16; a++) reg_rw(1'b1, a, rnd());
      for (int a = 0; a < 16; a++) reg_rw(1'b0, a, 32'h0);
      // positive, active-only, disabled, active-negative setups
      for (int c = 0; c < 4; c++) begin
         reg_rw(1'b1, 0, (c >= 2 ? 32'h00800000 : 32'h0)
            | (rnd() & 32'h001FFFFF));
         reg_rw(1'b1, 1, c == 1 ? 32'h00800000 : (c == 2 ?
            32'h00900000 : rnd() & 32'h001FFFFF));
         reg_rw(1'b1, 2, (c == 2 ? 32'h00800000 : 32'h0)
            | (rnd() & 32'h001FFFFF));
         reg_rw(1'b1, 4, (32'h00002507 >> (4 * c)) & 32'h7);
         for (int k = 0; k < 30; k++) begin
            upd();
            if (k % 6 == 5) serve();
         end
      end
      results();
   end
endmodule : tb_phase_no_load_detector
